// ---- rtl/hrc_host.sv ----
// host controller: unlocks the hidden clock and moves its 64 bits
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "hrc_map.svh"
module hrc_host (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic powerFailThreshold,
  output logic [16:0] memAddr,
  output logic ceN,
  output logic oeN,
  output logic weN,
  output logic rstN,
  input wire logic serialDataLineIn,
  output logic serialDataLineOut,
  output logic serialDataLineOe
);
  hrc_cyc_if cyc ();
  hrc_pkg::hrc_state_t state_reg;
  logic [6:0] idx_reg;
  logic [63:0] time_reg;
  logic [16:0] addr_reg;
  logic dir_reg;
  logic done_reg;
  logic go;
  logic [31:0] rdata_reg;
  hrc_pkg::hrc_cyc_t kind;
  logic bitOut;
  localparam logic [63:0] KEY_PATTERN = `HRC_PATTERN;
  // ------------------------------------------------------------
  // bus cycle engine
  // ------------------------------------------------------------
  hrc_bus_cycle u_cyc (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .cyc(cyc.eng),
    .dq0In(serialDataLineIn),
    .ceN(ceN),
    .oeN(oeN),
    .weN(weN),
    .dq0Out(serialDataLineOut),
    .dq0Oe(serialDataLineOe)
  );
  // the device ignores bus cycles during power fail, so no new sequence starts; one under way runs on
  assign go = regWrite && regAddr == `HRC_OFS_CTRL && regWdata[`HRC_CTRL_GO]
    && !powerFailThreshold;
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= hrc_pkg::HRC_IDLE;
      idx_reg <= 7'h0;
    end else begin
      case (state_reg)
        hrc_pkg::HRC_IDLE: begin
          if (go) begin
            state_reg <= hrc_pkg::HRC_OPEN;
            idx_reg <= 7'h0;
          end
        end
        hrc_pkg::HRC_OPEN: begin
          if (cyc.done) begin
            state_reg <= hrc_pkg::HRC_KEY;
          end
        end
        hrc_pkg::HRC_KEY: begin
          if (cyc.done) begin
            if (idx_reg == `HRC_BITS - 7'd1) begin
              idx_reg <= 7'h0;
              state_reg <= hrc_pkg::HRC_XFER;
            end else begin
              idx_reg <= idx_reg + 7'd1;
            end
          end
        end
        hrc_pkg::HRC_XFER: begin
          if (cyc.done) begin
            if (idx_reg == `HRC_BITS - 7'd1) begin
              state_reg <= hrc_pkg::HRC_DONE;
            end else begin
              idx_reg <= idx_reg + 7'd1;
            end
          end
        end
        hrc_pkg::HRC_DONE: begin
          state_reg <= hrc_pkg::HRC_IDLE;
        end
        default: begin
          state_reg <= hrc_pkg::HRC_IDLE;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // cycle requests
  // ------------------------------------------------------------
  always_comb begin
    kind = hrc_pkg::HRC_CYC_NONE;
    bitOut = 1'b0;
    case (state_reg)
      hrc_pkg::HRC_OPEN: kind = hrc_pkg::HRC_CYC_READ;
      hrc_pkg::HRC_KEY: begin
        kind = hrc_pkg::HRC_CYC_WRITE;
        bitOut = KEY_PATTERN[idx_reg[5:0]];
      end
      hrc_pkg::HRC_XFER: begin
        kind = dir_reg ? hrc_pkg::HRC_CYC_WRITE : hrc_pkg::HRC_CYC_READ;
        bitOut = time_reg[idx_reg[5:0]];
      end
      default: kind = hrc_pkg::HRC_CYC_NONE;
    endcase
  end
  assign cyc.start = (kind != hrc_pkg::HRC_CYC_NONE) && !cyc.done;
  assign cyc.kind = kind;
  assign cyc.bitOut = bitOut;
  assign memAddr = addr_reg;
  assign rstN = 1'b1;
  // ------------------------------------------------------------
  // time image: all 64 bits move in one pass
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      time_reg <= 64'h0;
    end else if (state_reg == hrc_pkg::HRC_XFER && cyc.done && !dir_reg) begin
      time_reg[idx_reg[5:0]] <= cyc.bitIn;
    end else if (state_reg == hrc_pkg::HRC_IDLE && regWrite) begin
      if (regAddr == `HRC_OFS_TIME_LO) begin
        time_reg[31:0] <= regWdata;
      end else if (regAddr == `HRC_OFS_TIME_HI) begin
        time_reg[63:32] <= regWdata;
      end
    end
  end
  // ------------------------------------------------------------
  // configuration and status
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      addr_reg <= 17'h0;
      dir_reg <= 1'b0;
    end else if (state_reg == hrc_pkg::HRC_IDLE && regWrite) begin
      if (regAddr == `HRC_OFS_ADDR) begin
        addr_reg <= regWdata[16:0];
      end
      if (go) begin
        dir_reg <= regWdata[`HRC_CTRL_WRITE];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
    end else if (state_reg == hrc_pkg::HRC_DONE) begin
      done_reg <= 1'b1;
    end else if (go) begin
      done_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_reg <= 32'h0;
    end else if (regRead) begin
      case (regAddr)
        `HRC_OFS_STATUS: rdata_reg <= {29'h0, powerFailThreshold, done_reg,
          state_reg != hrc_pkg::HRC_IDLE};
        `HRC_OFS_ADDR: rdata_reg <= {15'h0, addr_reg};
        `HRC_OFS_CTRL: rdata_reg <= {30'h0, dir_reg, 1'b0};
        `HRC_OFS_TIME_LO: rdata_reg <= time_reg[31:0];
        `HRC_OFS_TIME_HI: rdata_reg <= time_reg[63:32];
        default: rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end
  assign regRdata = rdata_reg;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_open;
    state_reg == hrc_pkg::HRC_OPEN && !ceN;
  endsequence
  sequence s_idle_pfail;
    powerFailThreshold && state_reg == hrc_pkg::HRC_IDLE;
  endsequence
  AST_NO_START_IN_PFAIL: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_idle_pfail |=> state_reg == hrc_pkg::HRC_IDLE) else $error("start during power fail");
  AST_OPEN_IS_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_open |-> !oeN && weN) else $error("opening cycle not a read");
  AST_KEY_IS_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_reg == hrc_pkg::HRC_KEY && !ceN |-> !weN && oeN && serialDataLineOe)
    else $error("key cycle not a write");
  AST_STROBES_EXCL: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !(!oeN && !weN)) else $error("oe and we both low");
  AST_OE_ONLY_ON_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    serialDataLineOe |-> !weN) else $error("data driven outside write");
  AST_KEY_TO_XFER: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_reg == hrc_pkg::HRC_KEY && cyc.done && idx_reg == 7'd63
    |=> state_reg == hrc_pkg::HRC_XFER && idx_reg == 7'd0) else $error("bad unlock count");
  AST_KEY_BIT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_reg == hrc_pkg::HRC_KEY && !weN |-> serialDataLineOut == KEY_PATTERN[idx_reg[5:0]])
    else $error("wrong key bit");
  AST_ADDR_STABLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !ceN |=> $stable(memAddr)) else $error("address moved in cycle");
endmodule : hrc_host

// ---- rtl/hrc_map.svh ----
// constants of the hidden clock access controller
// How it works
// - unlock needs 64 consecutive writes whose data bit 0 matches the pattern
// - the sequence opens with one read cycle that resets the compare pointer
// - unlock writes go to one scratch address, whose ram byte is overwritten
// - the pattern is sent least significant bit first
// - clock data moves bit 0 of register 0 through bit 7 of register 7
// - registers are written and read as whole 8-bit groups
`ifndef HRC_MAP_SVH
`define HRC_MAP_SVH
// ------------------------------------------------------------
// software register offsets
// ------------------------------------------------------------
`define HRC_OFS_CTRL 4'h0
`define HRC_OFS_STATUS 4'h1
`define HRC_OFS_ADDR 4'h2
`define HRC_OFS_TIME_LO 4'h3
`define HRC_OFS_TIME_HI 4'h4
// ------------------------------------------------------------
// control and status fields
// ------------------------------------------------------------
`define HRC_CTRL_GO 0
`define HRC_CTRL_WRITE 1
`define HRC_STAT_BUSY 0
`define HRC_STAT_DONE 1
`define HRC_STAT_PFAIL 2
// ------------------------------------------------------------
// pattern and counts
// ------------------------------------------------------------
`define HRC_PATTERN 64'h5ca33ac55ca33ac5
`define HRC_BITS 7'd64
`define HRC_CYC_NS 80
`define HRC_CLK_NS 8
`define HRC_PHASE_CYC ((`HRC_CYC_NS + `HRC_CLK_NS - 1) / `HRC_CLK_NS)
`define HRC_RST_NS 65
`define HRC_RST_CYC ((`HRC_RST_NS + `HRC_CLK_NS - 1) / `HRC_CLK_NS)
`endif

// ---- rtl/hrc_pkg.sv ----
// types of the hidden clock access controller
package hrc_pkg;
  typedef enum {
    HRC_IDLE,
    HRC_OPEN,
    HRC_KEY,
    HRC_XFER,
    HRC_GAP,
    HRC_DONE
  } hrc_state_t;
  typedef enum logic [1:0] {
    HRC_CYC_NONE,
    HRC_CYC_READ,
    HRC_CYC_WRITE
  } hrc_cyc_t;
endpackage : hrc_pkg

// ---- rtl/hrc_cyc_if.sv ----
// handshake between sequencer and bus cycle engine
`timescale 1ns/1ps
interface hrc_cyc_if;
  logic start;
  hrc_pkg::hrc_cyc_t kind;
  logic bitOut;
  logic bitIn;
  logic done;
  modport seq (output start, output kind, output bitOut, input bitIn, input done);
  modport eng (input start, input kind, input bitOut, output bitIn, output done);
endinterface : hrc_cyc_if

// ---- rtl/hrc_bus_cycle.sv ----
// one sram bus cycle: strobes low for a phase, then a recovery phase
`timescale 1ns/1ps
`include "hrc_map.svh"
module hrc_bus_cycle (
  input wire logic clk_sys,
  input wire logic reset_n,
  hrc_cyc_if.eng cyc,
  input wire logic dq0In,
  output logic ceN,
  output logic oeN,
  output logic weN,
  output logic dq0Out,
  output logic dq0Oe
);
  logic [3:0] cnt_reg;
  logic active_reg;
  logic recov_reg;
  logic isWrite_reg;
  logic bit_reg;
  logic sample_reg;
  logic doneP_reg;
  // ------------------------------------------------------------
  // strobe timing
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      active_reg <= 1'b0;
      recov_reg <= 1'b0;
      cnt_reg <= 4'h0;
      isWrite_reg <= 1'b0;
      bit_reg <= 1'b0;
      doneP_reg <= 1'b0;
    end else begin
      doneP_reg <= 1'b0;
      if (!active_reg && !recov_reg && cyc.start && cyc.kind != hrc_pkg::HRC_CYC_NONE) begin
        active_reg <= 1'b1;
        isWrite_reg <= (cyc.kind == hrc_pkg::HRC_CYC_WRITE);
        bit_reg <= cyc.bitOut;
        cnt_reg <= 4'(`HRC_PHASE_CYC - 1);
      end else if (active_reg) begin
        if (cnt_reg == 4'h0) begin
          active_reg <= 1'b0;
          recov_reg <= 1'b1;
          cnt_reg <= 4'(`HRC_PHASE_CYC - 1);
        end else begin
          cnt_reg <= cnt_reg - 4'h1;
        end
      end else if (recov_reg) begin
        if (cnt_reg == 4'h0) begin
          recov_reg <= 1'b0;
          doneP_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 4'h1;
        end
      end
    end
  end
  // ------------------------------------------------------------
  // read data capture at end of strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sample_reg <= 1'b0;
    end else if (active_reg && cnt_reg == 4'h0 && !isWrite_reg) begin
      sample_reg <= dq0In;
    end
  end
  assign ceN = !active_reg;
  assign oeN = !(active_reg && !isWrite_reg);
  assign weN = !(active_reg && isWrite_reg);
  assign dq0Out = bit_reg;
  assign dq0Oe = active_reg && isWrite_reg;
  assign cyc.bitIn = sample_reg;
  assign cyc.done = doneP_reg;
endmodule : hrc_bus_cycle

// ---- test/hrc_dev_model.sv ----
// device model: hidden clock behind an sram, reached on one data line
`timescale 1ns/1ps
`include "hrc_map.svh"
module hrc_dev_model (
  input wire logic clk_sys,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic rstN,
  input wire logic hostOut,
  input wire logic hostOe,
  input wire logic pfail,
  input wire logic slow,
  output logic devDq,
  output logic [63:0] timeBits,
  output logic [7:0] ramWrites,
  output logic [7:0] unlocks
);
  localparam logic [63:0] PAT = `HRC_PATTERN;
  localparam logic [63:0] ZMASK = 64'hff1f3f37bf7f7fff;
  logic [5:0] ptr = '0;
  logic [5:0] xcnt = '0;
  logic [2:0] lowCnt = '0;
  logic bad = 1'b0, isOpen = 1'b0, inCyc = 1'b0, wasRd = 1'b0, wasWr = 1'b0;
  logic capBit = 1'b0, lastOut = 1'b0, ramBit = 1'b0;
  wire logic dq = hostOe ? hostOut : devDq;
  initial begin
    // a run is far shorter than one hundredth, so the counters never carry here
    timeBits = '0;
    ramWrites = '0;
    unlocks = '0;
  end
  // ------------------------------------------------------------
  // read drive, late when slow, inverted when released
  // ------------------------------------------------------------
  always_comb begin
    if (!ceN && !oeN && !pfail && (!slow || lowCnt >= 3'd4)) begin
      devDq = isOpen ? timeBits[xcnt] : ramBit;
    end else begin
      devDq = ~lastOut;
    end
  end
  // ------------------------------------------------------------
  // cycle end: recognition, transfer, abort
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    lowCnt <= ceN ? 3'd0 : (lowCnt == 3'd7 ? lowCnt : lowCnt + 3'd1);
    inCyc <= !ceN;
    if (!ceN && !oeN) begin
      lastOut <= devDq;
    end
    if (!ceN) begin
      wasRd <= !oeN;
      wasWr <= !weN;
      capBit <= dq;
    end
    if (!rstN && !timeBits[36]) begin
      isOpen <= 1'b0;
      ptr <= '0;
    end else if (inCyc && ceN && !pfail) begin
      if (isOpen) begin
        if (wasWr) begin
          timeBits[xcnt] <= capBit & ZMASK[xcnt];
        end
        xcnt <= xcnt + 6'd1;
        isOpen <= (xcnt != 6'd63);
      end else if (wasRd) begin
        ptr <= '0;
        bad <= 1'b0;
      end else if (wasWr) begin
        ramBit <= capBit;
        ramWrites <= ramWrites + 8'd1;
        if (bad || capBit != PAT[ptr]) begin
          bad <= 1'b1;
        end else if (ptr == 6'd63) begin
          isOpen <= 1'b1;
          xcnt <= '0;
          ptr <= '0;
          unlocks <= unlocks + 8'd1;
        end else begin
          ptr <= ptr + 6'd1;
        end
      end
    end
  end
endmodule : hrc_dev_model

// ---- test/hrc_host_tb_top.sv ----
// testbench of the hidden clock host controller
`timescale 1ns/1ps
`include "hrc_map.svh"
module hrc_host_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = '0;
  logic [31:0] regWdata = '0;
  logic regWrite = 1'b0, regRead = 1'b0, pfail = 1'b0, slow = 1'b0;
  logic [31:0] regRdata, rd;
  logic [16:0] memAddr;
  logic ceN, oeN, weN, rstN, hostOut, hostOe, devDq;
  logic [63:0] timeBits;
  logic [7:0] ramWrites, unlocks, r0, u0;
  int fails = 0;
  int checks = 0;
  localparam logic [63:0] TVAL = 64'h2409250311563412;
  always #4 clk_sys = ~clk_sys;
  hrc_host dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .powerFailThreshold(pfail), .memAddr(memAddr), .ceN(ceN), .oeN(oeN), .weN(weN),
    .rstN(rstN), .serialDataLineIn(devDq), .serialDataLineOut(hostOut),
    .serialDataLineOe(hostOe));
  hrc_dev_model dev_u (.clk_sys(clk_sys), .ceN(ceN), .oeN(oeN), .weN(weN), .rstN(rstN),
    .hostOut(hostOut), .hostOe(hostOe), .pfail(pfail), .slow(slow), .devDq(devDq),
    .timeBits(timeBits), .ramWrites(ramWrites), .unlocks(unlocks));
  // ------------------------------------------------------------
  // bus tasks and compare
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rdreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask : rdreg
  task automatic wait_done();
    int n = 0;
    rd = '0;
    while (rd[1] !== 1'b1 && n < 6000) begin
      rdreg(`HRC_OFS_STATUS, rd);
      n++;
    end
    chk(64'(rd[1]), 64'h1);
  endtask : wait_done
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdreg(`HRC_OFS_STATUS, rd);
    chk(rd, 64'h0);
    chk({ceN, oeN, weN, hostOe}, 64'he);
  endtask : t_reset
  task automatic t_write();
    r0 = ramWrites;
    u0 = unlocks;
    wr(`HRC_OFS_ADDR, 32'h1abcd);
    wr(`HRC_OFS_TIME_LO, TVAL[31:0]);
    wr(`HRC_OFS_TIME_HI, TVAL[63:32]);
    wr(`HRC_OFS_CTRL, 32'h3);
    wr(`HRC_OFS_CTRL, 32'h3);
    wait_done();
    chk(rd, 64'h2);
    chk(timeBits, TVAL);
    chk(8'(ramWrites - r0), 64'd64);
    chk(8'(unlocks - u0), 64'd1);
    chk(memAddr, 64'h1abcd);
    chk(rstN, 64'h1);
  endtask : t_write
  task automatic t_read();
    u0 = unlocks;
    @(posedge clk_sys);
    slow <= 1'b1;
    wr(`HRC_OFS_TIME_LO, ~TVAL[31:0]);
    wr(`HRC_OFS_TIME_HI, ~TVAL[63:32]);
    wr(`HRC_OFS_CTRL, 32'h1);
    wait_done();
    rdreg(`HRC_OFS_TIME_LO, rd);
    chk(rd, TVAL[31:0]);
    rdreg(`HRC_OFS_TIME_HI, rd);
    chk(rd, TVAL[63:32]);
    chk(timeBits, TVAL);
    chk(8'(unlocks - u0), 64'd1);
    slow <= 1'b0;
  endtask : t_read
  task automatic t_pfail();
    u0 = unlocks;
    @(posedge clk_sys);
    pfail <= 1'b1;
    wr(`HRC_OFS_CTRL, 32'h3);
    repeat (40) @(posedge clk_sys);
    rdreg(`HRC_OFS_STATUS, rd);
    chk({rd[2], rd[0]}, 64'h2);
    chk(8'(unlocks - u0), 64'd0);
    rdreg(4'hf, rd);
    chk(rd, 64'h0);
    pfail <= 1'b0;
  endtask : t_pfail
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_pfail();
    results();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    results();
  end
endmodule : hrc_host_tb_top
